// ### verilog/dd3_pkg.sv
// Shared constants and types for the DDR3 device core
package dd3_pkg;

  // ****************************************************************
  // Geometry and latency
  // ****************************************************************
  localparam int NW      = 8;
  localparam int LANES   = 8;
  localparam int MEM_DW  = NW * LANES;
  localparam int MEM_AW  = 8;
  localparam int BANKS   = 8;
  localparam int ROW_W   = 15;
  localparam int CL_CYC  = 5;
  localparam int CWL_CYC = 5;
  localparam int ZQL_CYC = 16;
  localparam int ZQS_CYC = 8;

  // ****************************************************************
  // Mode register fields and address pins
  // ****************************************************************
  localparam logic [1:0] BL_FIX8  = 2'h0;
  localparam logic [1:0] BL_OTF   = 2'h1;
  localparam logic [1:0] BL_FIX4  = 2'h2;
  localparam logic [1:0] MR0_SEL  = 2'h0;
  localparam logic [1:0] MR1_SEL  = 2'h1;
  localparam int         MR_BL_LO = 0;
  localparam int         MR_BT    = 3;
  localparam int         MR1_DLL  = 0;
  localparam int         A_AP     = 10;
  localparam int         A_BC     = 12;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    C_MRS = 3'h0, C_REF = 3'h1, C_PRE = 3'h2, C_ACT = 3'h3,
    C_WR  = 3'h4, C_RD  = 3'h5, C_ZQ  = 3'h6, C_NOP = 3'h7
  } dd3_cmd_type;

  typedef struct packed {
    logic             cs_n;
    logic             ras_n;
    logic             cas_n;
    logic             we_n;
    logic [2:0]       ba;
    logic [ROW_W-1:0] addr;
  } dd3_ca_type;

  typedef struct packed {
    logic [NW-1:0] rise;
    logic [NW-1:0] fall;
  } dd3_pair_type;

  typedef struct packed {
    logic       wr;
    logic       ap;
    logic       bc4;
    logic [2:0] ba;
    logic [2:0] col;
  } dd3_burst_type;

  typedef enum logic [3:0] {
    PS_RUN = 4'h1, PS_SREF = 4'h2, PS_PDN = 4'h4, PS_ZQ = 4'h8
  } dd3_pwr_type;

  typedef enum logic [3:0] {
    BS_IDLE = 4'h1, BS_WAIT = 4'h2, BS_PRE = 4'h4, BS_DATA = 4'h8
  } dd3_bst_type;

endpackage : dd3_pkg

// ### verilog/dd3_mem.sv
// Core array of eight byte lanes with registered read data
`timescale 1ns/1ps
module dd3_mem (
  input  logic                       i_clk,
  input  logic [dd3_pkg::MEM_AW-1:0] i_addr,
  input  logic                       i_re,
  input  logic [dd3_pkg::LANES-1:0]  i_we,
  input  logic [dd3_pkg::MEM_DW-1:0] i_wdata,
  output logic [dd3_pkg::MEM_DW-1:0] o_rdata
);
  import dd3_pkg::*;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [NW-1:0] arr [2**MEM_AW];
    logic [NW-1:0] rd;
    logic [NW-1:0] next_rd;
    always_comb begin
      next_rd = i_re ? arr[i_addr] : rd;
    end
    always_ff @(posedge i_clk) begin
      if (i_we[g]) begin
        arr[i_addr] <= i_wdata[g*NW +: NW];
      end
      rd <= next_rd;
    end
    assign o_rdata[g*NW +: NW] = rd;
  end

endmodule : dd3_mem

// ### verilog/dd3_core.sv
// DDR3 device core: command decode, bank state, bursts and pin data
`timescale 1ns/1ps
module dd3_core (
  input  logic                  i_ref_clk,
  input  logic                  i_rstn,
  input  logic                  i_ce,
  input  logic                  i_ck,
  input  logic                  i_cke,
  input  dd3_pkg::dd3_ca_type   i_ca,
  input  dd3_pkg::dd3_pair_type i_dq,
  output dd3_pkg::dd3_pair_type o_dq,
  output logic                  o_dq_oe_n,
  input  logic                  i_dqs,
  output logic                  o_dqs,
  output logic                  o_dqs_oe_n,
  output logic                  o_self_refresh,
  output logic                  o_power_down,
  output logic                  o_dll_off,
  output logic                  o_burst_done
);
  import dd3_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  dd3_cmd_type      cmd;
  dd3_pwr_type      pst;
  dd3_pwr_type      next_pst;
  dd3_bst_type      bst;
  dd3_bst_type      next_bst;
  dd3_burst_type    bur;
  dd3_burst_type    next_bur;
  dd3_pair_type     next_dq;
  logic             cke_q;
  logic [4:0]       zcnt;
  logic [4:0]       next_zcnt;
  logic [3:0]       cnt;
  logic [3:0]       next_cnt;
  logic [1:0]       bl_mode;
  logic [1:0]       next_bl_mode;
  logic             bt;
  logic             next_bt;
  logic             dll_off;
  logic             next_dll_off;
  logic [BANKS-1:0] bank_open;
  logic [BANKS-1:0] next_open;
  logic [ROW_W-1:0] row [BANKS];
  logic [ROW_W-1:0] next_row [BANKS];
  logic [MEM_AW-1:0] madr;
  logic [MEM_AW-1:0] next_madr;
  logic [MEM_AW-1:0] mem_addr;
  logic [LANES-1:0] lanes;
  logic [LANES-1:0] next_lanes;
  logic [LANES-1:0] mem_we;
  logic [MEM_DW-1:0] word;
  logic [MEM_DW-1:0] next_word;
  logic [MEM_DW-1:0] rdata;
  logic [2:0]       ba;
  logic [2:0]       i0;
  logic [2:0]       i1;
  logic             a10;
  logic             live;
  logic             act_go;
  logic             rd_go;
  logic             wr_go;
  logic             pre_go;
  logic             mrs_go;
  logic             zq_go;
  logic             bc4_sel;
  logic             beat;
  logic             last;
  logic             wr_last;
  logic             ap_close;
  logic             btgl;
  logic             next_btgl;
  logic             next_dqs;
  logic             next_dq_oe_n;
  logic             next_dqs_oe_n;

  function automatic logic [2:0] beat_idx(input logic [2:0] s,
                                          input logic [2:0] k,
                                          input logic       il);
    beat_idx = il ? (s ^ k) : {s[2] ^ k[2], 2'(s[1:0] + k[1:0])};
  endfunction : beat_idx

  // ****************************************************************
  // Command decode
  // ****************************************************************
  assign cmd  = dd3_cmd_type'({i_ca.ras_n, i_ca.cas_n, i_ca.we_n});
  assign ba   = i_ca.ba;
  assign a10  = i_ca.addr[A_AP];
  // Commands count only with clock enable high on this and last edge
  assign live = !i_ca.cs_n && cke_q && i_cke && pst == PS_RUN;
  assign act_go = live && cmd == C_ACT;
  assign pre_go = live && cmd == C_PRE;
  assign mrs_go = live && cmd == C_MRS;
  assign zq_go  = live && cmd == C_ZQ;
  // Only one burst in flight; a column command during one is dropped
  assign rd_go  = live && cmd == C_RD && !dll_off && bank_open[ba]
                  && bst == BS_IDLE;
  assign wr_go  = live && cmd == C_WR && !dll_off && bank_open[ba]
                  && bst == BS_IDLE;
  assign bc4_sel = bl_mode == BL_FIX4 ||
                   (bl_mode == BL_OTF && !i_ca.addr[A_BC]);

  // ****************************************************************
  // Power state and mode bits
  // ****************************************************************
  always_comb begin
    next_pst     = pst;
    next_zcnt    = zcnt;
    next_bl_mode = bl_mode;
    next_bt      = bt;
    next_dll_off = dll_off;
    unique case (pst)
      PS_RUN: begin
        if (cke_q && !i_cke) begin
          next_pst = (!i_ca.cs_n && cmd == C_REF) ? PS_SREF
                                                 : PS_PDN;
        end else if (zq_go) begin
          next_pst  = PS_ZQ;
          next_zcnt = a10 ? 5'(ZQL_CYC - 1) : 5'(ZQS_CYC - 1);
        end
      end
      PS_SREF, PS_PDN: begin
        if (i_cke) begin
          next_pst = PS_RUN;
        end
      end
      PS_ZQ: begin
        if (zcnt == 5'h0) begin
          next_pst = PS_RUN;
        end else begin
          next_zcnt = zcnt - 5'h1;
        end
      end
    endcase
    if (mrs_go && ba[1:0] == MR0_SEL) begin
      next_bl_mode = i_ca.addr[MR_BL_LO +: 2];
      next_bt      = i_ca.addr[MR_BT];
    end
    if (mrs_go && ba[1:0] == MR1_SEL) begin
      next_dll_off = i_ca.addr[MR1_DLL];
    end
  end

  // Positive edge: true clock rising, the complement falling
  always_ff @(posedge i_ck or negedge i_rstn) begin
    if (!i_rstn) begin
      pst     <= PS_RUN;
      zcnt    <= 5'h0;
      cke_q   <= 1'b0;
      bl_mode <= BL_FIX8;
      bt      <= 1'b0;
      dll_off <= 1'b0;
    end else begin
      pst     <= next_pst;
      zcnt    <= next_zcnt;
      cke_q   <= i_cke;
      bl_mode <= next_bl_mode;
      bt      <= next_bt;
      dll_off <= next_dll_off;
    end
  end

  // ****************************************************************
  // Bank state
  // ****************************************************************
  for (genvar g = 0; g < BANKS; g++) begin : g_bank
    assign next_open[g] = (act_go && ba == 3'(g)) ? 1'b1 :
                          ((pre_go && (a10 || ba == 3'(g))) ||
                           (ap_close && bur.ba == 3'(g))) ? 1'b0 :
                          bank_open[g];
    assign next_row[g]  = (act_go && ba == 3'(g)) ? i_ca.addr : row[g];
  end

  always_ff @(posedge i_ck or negedge i_rstn) begin
    if (!i_rstn) begin
      bank_open <= '0;
      row       <= '{default: '0};
    end else begin
      bank_open <= next_open;
      row       <= next_row;
    end
  end

  // ****************************************************************
  // Burst engine
  // ****************************************************************
  assign i0   = beat_idx(bur.col, {cnt[1:0], 1'b0}, bt);
  assign i1   = beat_idx(bur.col, {cnt[1:0], 1'b1}, bt);
  assign last = bur.bc4 ? cnt == 4'h1 : cnt == 4'h3;
  // Writes advance only on a strobe; reads advance every cycle
  assign beat = bst == BS_DATA && (!bur.wr || i_dqs);
  assign wr_last  = beat && bur.wr && last;
  assign ap_close = beat && last && bur.ap;
  assign mem_addr = (bst == BS_IDLE)
                    ? {ba, row[ba][1:0], i_ca.addr[5:3]} : madr;
  // One wide core write per burst, chopped bursts fill four lanes
  assign mem_we   = wr_last ? next_lanes : '0;

  always_comb begin
    next_bst   = bst;
    next_bur   = bur;
    next_cnt   = cnt;
    next_madr  = madr;
    next_word  = word;
    next_lanes = lanes;
    next_btgl  = btgl;
    unique case (bst)
      BS_IDLE: begin
        if (rd_go || wr_go) begin
          next_bur = '{wr: wr_go, ap: a10, bc4: bc4_sel, ba: ba,
                       col: i_ca.addr[2:0]};
          next_cnt   = wr_go ? 4'(CWL_CYC - 3) : 4'(CL_CYC - 3);
          next_madr  = mem_addr;
          next_lanes = '0;
          next_bst   = BS_WAIT;
        end
      end
      BS_WAIT: begin
        if (cnt == 4'h0) begin
          next_bst = BS_PRE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      BS_PRE: begin
        // A write waits for the strobe to sit low through its preamble
        if (!bur.wr || !i_dqs) begin
          next_bst = BS_DATA;
          next_cnt = 4'h0;
        end
      end
      BS_DATA: begin
        if (beat) begin
          if (bur.wr) begin
            next_word[i0*NW +: NW] = i_dq.rise;
            next_word[i1*NW +: NW] = i_dq.fall;
            next_lanes[i0] = 1'b1;
            next_lanes[i1] = 1'b1;
          end
          next_cnt = cnt + 4'h1;
          if (last) begin
            next_bst  = BS_IDLE;
            next_btgl = !btgl;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_ck or negedge i_rstn) begin
    if (!i_rstn) begin
      bst   <= BS_IDLE;
      bur   <= '0;
      cnt   <= 4'h0;
      madr  <= '0;
      word  <= '0;
      lanes <= '0;
      btgl  <= 1'b0;
    end else begin
      bst   <= next_bst;
      bur   <= next_bur;
      cnt   <= next_cnt;
      madr  <= next_madr;
      word  <= next_word;
      lanes <= next_lanes;
      btgl  <= next_btgl;
    end
  end

  dd3_mem u_mem (
    .i_clk   (i_ck),
    .i_addr  (mem_addr),
    .i_re    (rd_go),
    .i_we    (mem_we),
    .i_wdata (next_word),
    .o_rdata (rdata)
  );

  // ****************************************************************
  // Read pins: strobe and data change together
  // ****************************************************************
  always_comb begin
    next_dq       = '0;
    next_dqs      = 1'b0;
    next_dq_oe_n  = 1'b1;
    next_dqs_oe_n = 1'b1;
    if (bst == BS_PRE && !bur.wr) begin
      next_dqs_oe_n = 1'b0;
    end
    if (bst == BS_DATA && !bur.wr) begin
      next_dqs_oe_n = 1'b0;
      next_dq_oe_n  = 1'b0;
      next_dqs      = 1'b1;
      next_dq.rise  = rdata[i0*NW +: NW];
      next_dq.fall  = rdata[i1*NW +: NW];
    end
  end

  always_ff @(posedge i_ck or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dq       <= '0;
      o_dqs      <= 1'b0;
      o_dq_oe_n  <= 1'b1;
      o_dqs_oe_n <= 1'b1;
    end else begin
      o_dq       <= next_dq;
      o_dqs      <= next_dqs;
      o_dq_oe_n  <= next_dq_oe_n;
      o_dqs_oe_n <= next_dqs_oe_n;
    end
  end

  // ****************************************************************
  // Status crossing into the reference clock domain
  // ****************************************************************
  // Synchroniser stages run free so that nothing else reads stage one
  logic [3:0] lvl;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       tq;
  logic       next_tq;
  logic [3:0] next_stat;
  assign lvl = {btgl, pst[1], pst[2], dll_off};

  always_comb begin
    next_tq   = i_ce ? sync2[3] : tq;
    next_stat = {o_burst_done, o_self_refresh, o_power_down, o_dll_off};
    if (i_ce) begin
      next_stat = {sync2[3] ^ tq, sync2[2:0]};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1          <= 4'h0;
      sync2          <= 4'h0;
      tq             <= 1'b0;
      o_burst_done   <= 1'b0;
      o_self_refresh <= 1'b0;
      o_power_down   <= 1'b0;
      o_dll_off      <= 1'b0;
    end else begin
      sync1 <= lvl;
      sync2 <= sync1;
      tq    <= next_tq;
      {o_burst_done, o_self_refresh, o_power_down, o_dll_off}
            <= next_stat;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  localparam int A_CL = CL_CYC;
  default clocking cb @(posedge i_ck); endclocking
  default disable iff (!i_rstn);

  sequence rd_pre_s;
    o_dqs == 1'b0 && !o_dqs_oe_n && o_dq_oe_n;
  endsequence
  sequence rd_beat_s;
    o_dqs && !o_dqs_oe_n && !o_dq_oe_n;
  endsequence

  a_read_latency: assert property (rd_go |-> ##A_CL rd_pre_s ##1 rd_beat_s)
    else $error("read strobe preamble or first pair late");
  a_bc4_length: assert property (rd_go && bc4_sel |-> ##A_CL rd_pre_s
                                 ##1 rd_beat_s [*2] ##1 o_dqs_oe_n)
    else $error("chopped read burst not two cycles");
  a_bl8_length: assert property (rd_go && !bc4_sel |-> ##A_CL rd_pre_s
                                 ##1 rd_beat_s [*4] ##1 !o_dqs)
    else $error("full read burst not four cycles");
  a_act_opens: assert property (act_go |=> bank_open[$past(ba)])
    else $error("activated bank not open");
  a_ap_closes: assert property (ap_close |=> !bank_open[$past(bur.ba)])
    else $error("auto precharge left bank open");
  a_write_lanes: assert property (wr_last |-> $countones(mem_we)
                                  == (bur.bc4 ? 4 : 8))
    else $error("write burst committed wrong lane count");
  a_sref_entry: assert property (pst == PS_RUN && cke_q && !i_cke
                                 && !i_ca.cs_n && cmd == C_REF
                                 |=> pst == PS_SREF)
    else $error("self refresh not entered");
  a_zq_long: assert property (zq_go && a10 |=> (pst == PS_ZQ) [*8])
    else $error("long calibration ended early");
  a_dll_gate: assert property (dll_off && live && cmd == C_RD
                               && bst == BS_IDLE |=> bst == BS_IDLE)
    else $error("column command taken with loop disabled");

endmodule : dd3_core

// ### verification/dd3_ctrl_model.sv
// Memory controller model: commands, clock enable and write data
`timescale 1ns/1ps
module dd3_ctrl_model (
  input  wire logic             i_ck,
  output dd3_pkg::dd3_ca_type   o_ca,
  output dd3_pkg::dd3_pair_type o_dq,
  output logic                  o_dqs,
  output logic                  o_cke
);
  import dd3_pkg::*;

  initial begin
    o_ca  = '1;
    o_dq  = '0;
    o_dqs = 1'b0;
    o_cke = 1'b1;
  end

  // ****************************************************************
  // Command issue
  // ****************************************************************
  // Pins change just after an edge so they are settled at the next one
  task cmd(input logic [2:0] op, input logic [2:0] ba, input logic [14:0] a);
    @(posedge i_ck) #1;
    o_ca = {1'b0, op, ba, a};
    @(posedge i_ck) #1;
    o_ca.cs_n = 1'b1;
    o_ca.addr = ~a;
  endtask : cmd

  task cke_set(input logic v, input logic with_ref);
    @(posedge i_ck) #1;
    o_cke = v;
    o_ca.cs_n = ~with_ref;
    {o_ca.ras_n, o_ca.cas_n, o_ca.we_n} = 3'b001;
    @(posedge i_ck) #1;
    o_ca.cs_n = 1'b1;
  endtask : cke_set

  // ****************************************************************
  // Write data
  // ****************************************************************
  // Released data lines flip so a stale value can never look valid
  task wr_burst(input logic [7:0] base, input int n);
    int c;
    repeat (CWL_CYC - 2) @(posedge i_ck);
    #1 o_dqs = 1'b0;
    for (c = 0; c < n; c++) begin
      @(posedge i_ck) #1;
      o_dqs = 1'b1;
      o_dq  = {base + 8'(2 * c), base + 8'(2 * c + 1)};
    end
    @(posedge i_ck) #1;
    o_dqs = 1'b0;
    o_dq  = ~o_dq;
  endtask : wr_burst
endmodule : dd3_ctrl_model

// ### verification/dd3_core_tb.sv
// Self-checking testbench for the DDR3 device core
`timescale 1ns/1ps
module dd3_core_tb;
  import dd3_pkg::*;

  logic         i_ref_clk;
  logic         i_rstn;
  logic         i_ck;
  logic         i_cke;
  logic         i_dqs;
  dd3_ca_type   i_ca;
  dd3_pair_type i_dq;
  dd3_pair_type o_dq;
  logic         o_dq_oe_n;
  logic         o_dqs;
  logic         o_dqs_oe_n;
  logic         o_self_refresh;
  logic         o_power_down;
  logic         o_dll_off;
  logic         o_burst_done;
  int           n_mismatch = 0;
  int           checks = 0;

  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  // Link clock free-runs at an unrelated phase
  initial begin
    i_ck = 1'b0;
    #7;
    forever #15 i_ck = ~i_ck;
  end

  dd3_core u_dd3_core (.i_ref_clk, .i_rstn, .i_ce(1'b1), .i_ck, .i_cke,
    .i_ca, .i_dq, .o_dq, .o_dq_oe_n, .i_dqs, .o_dqs, .o_dqs_oe_n,
    .o_self_refresh, .o_power_down, .o_dll_off, .o_burst_done);

  dd3_ctrl_model u_dd3_ctrl_model (.i_ck(i_ck), .o_ca(i_ca), .o_dq(i_dq),
    .o_dqs(i_dqs), .o_cke(i_cke));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic flag(input int w);
    case (w)
      0:       return o_self_refresh;
      1:       return o_power_down;
      2:       return o_dll_off;
      default: return o_burst_done;
    endcase
  endfunction : flag

  // Status flags live on the reference clock, so poll there with a bound
  task automatic wait_flag(input int w, input logic v);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge i_ref_clk) #1;
      if (flag(w) === v) break;
    end
    chk("status flag", {15'h0, v}, {15'h0, flag(w)});
    if (flag(w) !== v) report_and_stop();
  endtask : wait_flag

  // Entered just after the edge that took the read; n of 0 means refused
  task automatic rd_check(input logic [63:0] e, input int n);
    int c;
    repeat (CL_CYC - 2) @(posedge i_ck);
    #1 chk("dqs oe early", 16'h1, {15'h0, o_dqs_oe_n});
    @(posedge i_ck) #1;
    chk("dqs oe pre", (n > 0) ? 16'h0 : 16'h1, {15'h0, o_dqs_oe_n});
    chk("dqs pre", 16'h0, {15'h0, o_dqs});
    for (c = 0; c < n; c++) begin
      @(posedge i_ck) #1;
      chk("dqs data", 16'h1, {15'h0, o_dqs});
      chk("dq oe", 16'h0, {15'h0, o_dq_oe_n});
      chk("dq pair", e[63 - 16 * c -: 16], o_dq);
    end
    @(posedge i_ck) #1;
    chk("oe after", 16'h3, {14'h0, o_dq_oe_n, o_dqs_oe_n});
  endtask : rd_check

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task sc_rw_bl8;
    u_dd3_ctrl_model.cmd(3'b101, 3'h0, 15'h0000);
    rd_check(64'h0, 0);
    u_dd3_ctrl_model.cmd(3'b011, 3'h0, 15'h0005);
    u_dd3_ctrl_model.cmd(3'b100, 3'h0, 15'h0000);
    u_dd3_ctrl_model.wr_burst(8'h10, 4);
    wait_flag(3, 1'b1);
    u_dd3_ctrl_model.cmd(3'b101, 3'h0, 15'h0002);
    fork
      rd_check(64'h1213_1011_1617_1415, 4);
      u_dd3_ctrl_model.cmd(3'b011, 3'h1, 15'h0006);
    join
  endtask : sc_rw_bl8

  task sc_otf_ap;
    u_dd3_ctrl_model.cmd(3'b100, 3'h1, 15'h0000);
    u_dd3_ctrl_model.wr_burst(8'h40, 4);
    wait_flag(3, 1'b1);
    u_dd3_ctrl_model.cmd(3'b000, 3'h0, 15'h0001);
    u_dd3_ctrl_model.cmd(3'b101, 3'h1, 15'h0400);
    rd_check(64'h4041_4243_0000_0000, 2);
    u_dd3_ctrl_model.cmd(3'b101, 3'h1, 15'h0000);
    rd_check(64'h0, 0);
    u_dd3_ctrl_model.cmd(3'b101, 3'h0, 15'h1000);
    rd_check(64'h1011_1213_1415_1617, 4);
  endtask : sc_otf_ap

  task sc_dll_zq;
    int i;
    u_dd3_ctrl_model.cmd(3'b000, 3'h1, 15'h0001);
    wait_flag(2, 1'b1);
    u_dd3_ctrl_model.cmd(3'b101, 3'h0, 15'h1000);
    rd_check(64'h0, 0);
    u_dd3_ctrl_model.cmd(3'b000, 3'h1, 15'h0000);
    wait_flag(2, 1'b0);
    for (i = 0; i < 2; i++) begin
      u_dd3_ctrl_model.cmd(3'b110, 3'h0, (i == 0) ? 15'h0400 : 15'h0000);
      u_dd3_ctrl_model.cmd(3'b101, 3'h0, 15'h1000);
      rd_check(64'h0, 0);
      repeat (ZQL_CYC) @(posedge i_ck);
    end
  endtask : sc_dll_zq

  task sc_power;
    u_dd3_ctrl_model.cke_set(1'b0, 1'b1);
    wait_flag(0, 1'b1);
    u_dd3_ctrl_model.cke_set(1'b1, 1'b0);
    wait_flag(0, 1'b0);
    u_dd3_ctrl_model.cke_set(1'b0, 1'b0);
    wait_flag(1, 1'b1);
    u_dd3_ctrl_model.cke_set(1'b1, 1'b0);
    wait_flag(1, 1'b0);
    u_dd3_ctrl_model.cmd(3'b101, 3'h0, 15'h1000);
    rd_check(64'h1011_1213_1415_1617, 4);
    // Interleaved order from column five differs from sequential order
    u_dd3_ctrl_model.cmd(3'b000, 3'h0, 15'h0009);
    u_dd3_ctrl_model.cmd(3'b101, 3'h0, 15'h1005);
    rd_check(64'h1514_1716_1110_1312, 4);
    // Precharge of all banks leaves nothing to read
    u_dd3_ctrl_model.cmd(3'b010, 3'h0, 15'h0400);
    u_dd3_ctrl_model.cmd(3'b101, 3'h0, 15'h1000);
    rd_check(64'h0, 0);
  endtask : sc_power

  initial begin
    i_rstn = 1'b0;
    repeat (5) @(posedge i_ref_clk);
    chk("reset dq", 16'h0, o_dq);
    chk("reset outs", 16'h0050, {9'h0, o_dq_oe_n, o_dqs, o_dqs_oe_n,
        o_self_refresh, o_power_down, o_dll_off, o_burst_done});
    #1 i_rstn = 1'b1;
    repeat (3) @(posedge i_ck);
    sc_rw_bl8();
    sc_otf_ap();
    sc_dll_zq();
    sc_power();
    report_and_stop();
  end

  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : dd3_core_tb
